// ===== pkg/dcs_pkg.sv
// Constants for the DMA channel size and pointer register block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package dcs_pkg;
  localparam int ADDR_W = 8;
  localparam int LEN_W = 16;
  localparam int CNT_W = LEN_W + 1;

  // Register byte offsets
  localparam logic [7:0] OFS_DEST_LENGTH = 8'h00;
  localparam logic [7:0] OFS_SRC_PROGRESS = 8'h04;
  localparam logic [7:0] OFS_DEST_PROGRESS = 8'h08;
  localparam logic [7:0] OFS_BYTES_PER_TRIGGER = 8'h0c;
  localparam logic [7:0] OFS_SRC_LENGTH = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h14;
  localparam logic [7:0] OFS_INT_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1c;

  // Control fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_PATTERN_BIT = 1;
  localparam int CTL_BUSY_BIT = 8;
  localparam int CTL_W = 2;

  // Interrupt status and mask fields
  localparam int FLG_W = 6;
  localparam int FLG_SRC_DONE = 5;
  localparam int FLG_SRC_HALF = 4;
  localparam int FLG_DEST_DONE = 3;
  localparam int FLG_DEST_HALF = 2;
  localparam int FLG_BLOCK = 1;
  localparam int FLG_CELL = 0;

  // Reset values
  localparam logic [LEN_W-1:0] RST_LEN = 16'h0000;
  localparam logic [LEN_W-1:0] RST_PTR = 16'h0000;
  localparam logic [CTL_W-1:0] RST_CTL = 2'h0;
  localparam logic [FLG_W-1:0] RST_FLG = 6'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {DCS_IDLE, DCS_MOVE} dcs_state_e;
endpackage

// ===== hw/dcs_region_ptr.sv
// Progress pointer for one side of a channel region.
// Assumes step and clear are single-cycle pulses on aclk.
`timescale 1ns/10ps
module dcs_region_ptr #(
  parameter int LEN_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [LEN_W-1:0] length_field,
  input wire logic step,
  input wire logic clear,
  output logic [LEN_W-1:0] ptr,
  output logic [LEN_W:0] full_len,
  output logic done,
  output logic half
);
  logic [LEN_W-1:0] ptr_reg;
  logic [LEN_W:0] inc;

  // Zero length means the whole 2^LEN_W byte region
  assign full_len = {(length_field == '0), length_field};
  assign inc = {1'b0, ptr_reg} + {{LEN_W{1'b0}}, 1'b1};
  assign done = step && (inc == full_len);
  assign half = step && (inc == (full_len >> 1));
  assign ptr = ptr_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= '0;
    end else if (clear || done) begin
      // End of region returns to byte 0
      ptr_reg <= '0;
    end else if (step) begin
      ptr_reg <= inc[LEN_W-1:0];
    end
  end
endmodule

// ===== hw/dcs_channel_regs.sv
// DMA channel transfer geometry: sizes, progress pointers, cell engine.
// Assumes an AXI4-Lite master on aclk and a byte mover answering
// move_req with a one-cycle move_ack; trigger and pattern_match are
// pulses from logic on aclk.
// How it works
// R01 - Destination length field counts bytes; zero means 65,536.
// R02 - Upper sixteen bits of size and pointer registers read zero.
// R03 - Source progress pointer is read-only byte index 0 to 65,535.
// R04 - In pattern mode a match clears the source progress pointer.
// R05 - Destination progress pointer is read-only byte index from 0.
// R06 - A trigger moves one cell of trigger length, cut short at block end or pattern hit; zero means 65,536.
// R07 - Reset clears sizes, both pointers and cell size to zero.
// R08 - Source length field decodes like destination; zero means 65,536.
// R09 - Destination done at end, half flag at midpoint of destination.
// R10 - Cell complete flag sets after each full cell.
// R11 - Block complete after larger size moved, or on pattern match.
// R12 - Pointers advance per byte moved and wrap to zero at end.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module dcs_channel_regs #(
  parameter int ADDR_W = dcs_pkg::ADDR_W,
  parameter int LEN_W = dcs_pkg::LEN_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger,
  input wire logic pattern_match,
  output logic move_req,
  input wire logic move_ack,
  output logic [LEN_W-1:0] move_src_index,
  output logic [LEN_W-1:0] move_dest_index,
  output logic irq
);
  localparam int CNT_W = LEN_W + 1;

  logic [LEN_W-1:0] dest_length_field_reg, src_length_field_reg;
  logic [LEN_W-1:0] trigger_length_field_reg;
  logic [dcs_pkg::CTL_W-1:0] ctl_reg;
  logic [dcs_pkg::FLG_W-1:0] flag_reg, mask_reg;
  logic [CNT_W-1:0] cell_cnt_reg, block_cnt_reg;
  dcs_pkg::dcs_state_e state_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic aw_held_reg, w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [LEN_W-1:0] src_progress_field, dest_progress_field;
  logic [CNT_W-1:0] src_full, dest_full, cell_full, block_full;
  logic [CNT_W-1:0] cell_inc, block_inc;
  logic src_done, src_half, dest_done_flag_ev, dest_half_flag_ev;
  logic byte_step, cell_end, block_end, pattern_hit, wr_fire, rd_hit;
  logic [7:0] wr_ofs;
  logic [dcs_pkg::FLG_W-1:0] flag_set, flag_clr;
  logic [31:0] rd_word;

  // All checks run on aclk and rest while reset is held
  default clocking dcs_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic logic [LEN_W-1:0] merge16(
    input logic [LEN_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [LEN_W-1:0] res;
    res = old;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction

  // Byte engine
  assign pattern_hit = pattern_match && ctl_reg[dcs_pkg::CTL_PATTERN_BIT];
  assign move_req = (state_reg == dcs_pkg::DCS_MOVE);
  assign byte_step = move_req && move_ack;
  assign cell_full = {(trigger_length_field_reg == '0),
                      trigger_length_field_reg}; // R06
  assign block_full = (src_full > dest_full) ? src_full : dest_full; // R11
  assign cell_inc = cell_cnt_reg + {{LEN_W{1'b0}}, 1'b1};
  assign block_inc = block_cnt_reg + {{LEN_W{1'b0}}, 1'b1};
  assign cell_end = byte_step && (cell_inc == cell_full); // R10
  assign block_end = byte_step && (block_inc == block_full); // R11

  dcs_region_ptr #(
    .LEN_W(LEN_W)
  ) u_src_ptr (
    .aclk(aclk),
    .aresetn(aresetn),
    .length_field(src_length_field_reg), // R08
    .step(byte_step), // R12
    .clear(pattern_hit), // R04
    .ptr(src_progress_field), // R03
    .full_len(src_full),
    .done(src_done),
    .half(src_half)
  );

  dcs_region_ptr #(
    .LEN_W(LEN_W)
  ) u_dest_ptr (
    .aclk(aclk),
    .aresetn(aresetn),
    .length_field(dest_length_field_reg), // R01
    .step(byte_step), // R12
    .clear(1'b0),
    .ptr(dest_progress_field), // R05
    .full_len(dest_full),
    .done(dest_done_flag_ev), // R09
    .half(dest_half_flag_ev)
  );

  assign move_src_index = src_progress_field;
  assign move_dest_index = dest_progress_field;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= dcs_pkg::DCS_IDLE;
    end else begin
      case (state_reg)
        dcs_pkg::DCS_IDLE: begin
          if (trigger && ctl_reg[dcs_pkg::CTL_ENABLE_BIT]) begin
            state_reg <= dcs_pkg::DCS_MOVE;
          end
        end
        dcs_pkg::DCS_MOVE: begin
          // Pattern stop waits for no ack; mover must tolerate it
          if (cell_end || block_end || pattern_hit) begin
            state_reg <= dcs_pkg::DCS_IDLE;
          end
        end
        default: state_reg <= dcs_pkg::DCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_cnt_reg <= '0;
    end else if (cell_end || block_end || pattern_hit) begin
      cell_cnt_reg <= '0;
    end else if (byte_step) begin
      cell_cnt_reg <= cell_inc; // R06
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_cnt_reg <= '0;
    end else if (block_end || pattern_hit) begin
      block_cnt_reg <= '0;
    end else if (byte_step) begin
      block_cnt_reg <= block_inc;
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ofs = {aw_addr_reg[7:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dcs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (wr_ofs)
        dcs_pkg::OFS_DEST_LENGTH, dcs_pkg::OFS_SRC_PROGRESS,
        dcs_pkg::OFS_DEST_PROGRESS, dcs_pkg::OFS_BYTES_PER_TRIGGER,
        dcs_pkg::OFS_SRC_LENGTH, dcs_pkg::OFS_CONTROL,
        dcs_pkg::OFS_INT_STATUS, dcs_pkg::OFS_INT_MASK:
          s_axi_bresp <= dcs_pkg::RESP_OKAY;
        default: s_axi_bresp <= dcs_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Size registers; upper lanes are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_length_field_reg <= dcs_pkg::RST_LEN; // R07
      src_length_field_reg <= dcs_pkg::RST_LEN;
      trigger_length_field_reg <= dcs_pkg::RST_LEN;
    end else if (wr_fire) begin
      if (wr_ofs == dcs_pkg::OFS_DEST_LENGTH) begin
        dest_length_field_reg <=
          merge16(dest_length_field_reg, w_data_reg, w_strb_reg); // R02
      end
      if (wr_ofs == dcs_pkg::OFS_SRC_LENGTH) begin
        src_length_field_reg <=
          merge16(src_length_field_reg, w_data_reg, w_strb_reg);
      end
      if (wr_ofs == dcs_pkg::OFS_BYTES_PER_TRIGGER) begin
        trigger_length_field_reg <=
          merge16(trigger_length_field_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= dcs_pkg::RST_CTL;
      mask_reg <= dcs_pkg::RST_FLG;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (wr_ofs == dcs_pkg::OFS_CONTROL) begin
        ctl_reg <= w_data_reg[dcs_pkg::CTL_W-1:0];
      end
      if (wr_ofs == dcs_pkg::OFS_INT_MASK) begin
        mask_reg <= w_data_reg[dcs_pkg::FLG_W-1:0];
      end
    end
  end

  // Sticky event flags, write one to clear; a new event beats the clear
  always_comb begin
    flag_set = '0;
    flag_set[dcs_pkg::FLG_SRC_DONE] = src_done;
    flag_set[dcs_pkg::FLG_SRC_HALF] = src_half;
    flag_set[dcs_pkg::FLG_DEST_DONE] = dest_done_flag_ev; // R09
    flag_set[dcs_pkg::FLG_DEST_HALF] = dest_half_flag_ev; // R09
    flag_set[dcs_pkg::FLG_BLOCK] = block_end || pattern_hit; // R11
    flag_set[dcs_pkg::FLG_CELL] = cell_end; // R10
  end

  assign flag_clr = (wr_fire && wr_ofs == dcs_pkg::OFS_INT_STATUS &&
                     w_strb_reg[0]) ? w_data_reg[dcs_pkg::FLG_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= dcs_pkg::RST_FLG;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end
  end

  assign irq = |(flag_reg & mask_reg);

  // AXI4-Lite read side, one cycle to rvalid
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      dcs_pkg::OFS_DEST_LENGTH: rd_word[LEN_W-1:0] = dest_length_field_reg;
      dcs_pkg::OFS_SRC_PROGRESS: rd_word[LEN_W-1:0] = src_progress_field;
      dcs_pkg::OFS_DEST_PROGRESS: rd_word[LEN_W-1:0] = dest_progress_field;
      dcs_pkg::OFS_BYTES_PER_TRIGGER:
        rd_word[LEN_W-1:0] = trigger_length_field_reg;
      dcs_pkg::OFS_SRC_LENGTH: rd_word[LEN_W-1:0] = src_length_field_reg;
      dcs_pkg::OFS_CONTROL: begin
        rd_word[dcs_pkg::CTL_W-1:0] = ctl_reg;
        rd_word[dcs_pkg::CTL_BUSY_BIT] = move_req;
      end
      dcs_pkg::OFS_INT_STATUS: rd_word[dcs_pkg::FLG_W-1:0] = flag_reg;
      dcs_pkg::OFS_INT_MASK: rd_word[dcs_pkg::FLG_W-1:0] = mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dcs_pkg::RESP_OKAY;
      rd_addr_reg <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word; // R02
      s_axi_rresp <= rd_hit ? dcs_pkg::RESP_OKAY : dcs_pkg::RESP_SLVERR;
      rd_addr_reg <= s_axi_araddr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_reserved_zero: assert property ( // R02
    s_axi_rvalid && rd_addr_reg[7:2] <= 6'h04 |-> s_axi_rdata[31:16] == '0)
    else $error("upper half of size or pointer read not zero");
  a_reset_clears: assert property ( // R07
    $rose(aresetn) |-> dest_length_field_reg == '0 &&
    trigger_length_field_reg == '0 && src_progress_field == '0 &&
    dest_progress_field == '0)
    else $error("size or pointer not zero after reset");
  a_dest_len: assert property ( // R01
    dest_done_flag_ev |-> {1'b0, dest_progress_field} + 17'h00001 ==
    ((dest_length_field_reg == '0) ? 17'h10000 :
     {1'b0, dest_length_field_reg}))
    else $error("destination done at wrong length");
  a_src_len_wrap: assert property ( // R08
    src_done && !pattern_hit |-> ##1 src_progress_field == '0 &&
    $past(src_progress_field) == src_length_field_reg - 16'h0001)
    else $error("source pointer did not wrap at its length");
  a_src_step: assert property ( // R03
    byte_step && !src_done && !pattern_hit |=>
    src_progress_field == $past(src_progress_field) + 16'h0001)
    else $error("source pointer did not advance by one");
  a_pattern_clear: assert property ( // R04
    pattern_hit |=> src_progress_field == '0 && !move_req &&
    flag_reg[dcs_pkg::FLG_BLOCK])
    else $error("pattern match did not clear source pointer");
  a_dest_step: assert property ( // R05
    !byte_step |=> $stable(dest_progress_field))
    else $error("destination pointer moved without a byte");
  a_cell_length: assert property ( // R06
    cell_end |-> cell_cnt_reg + 17'h00001 ==
    ((trigger_length_field_reg == '0) ? 17'h10000 :
     {1'b0, trigger_length_field_reg}) ##1 !move_req)
    else $error("cell ended at wrong byte count");
  a_cell_flag: assert property ( // R10
    cell_end |=> flag_reg[dcs_pkg::FLG_CELL])
    else $error("cell complete flag not set");
  a_dest_half: assert property ( // R09
    dest_half_flag_ev |=> flag_reg[dcs_pkg::FLG_DEST_HALF] &&
    dest_progress_field == (dest_full[CNT_W-1:1]))
    else $error("destination half flag not at midpoint");
  a_block_larger: assert property ( // R11
    block_end |-> block_inc >= src_full && block_inc >= dest_full
    ##1 flag_reg[dcs_pkg::FLG_BLOCK] && block_cnt_reg == '0)
    else $error("block complete before larger size moved");
  a_dest_wrap: assert property ( // R12
    dest_done_flag_ev |=> dest_progress_field == '0)
    else $error("destination pointer did not return to zero");
endmodule

// ===== tb/dcs_mover_model.sv
// Behavioural byte mover on the far side of the channel.
// Assumes move_req is launched from a register on aclk.
`timescale 1ns/10ps
module dcs_mover_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic move_req,
  output logic move_ack
);
  logic phase_reg;

  // Slow mode answers every other cycle, so a cell can be cut short
  always_ff @(posedge aclk) begin
    if (!aresetn || !move_req) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  // One byte per ack, only while a cell is asked for
  assign move_ack = move_req && (!slow || phase_reg);
endmodule

// ===== tb/dcs_channel_regs_tb.sv
// Self-checking bench for the channel size and pointer registers.
// Assumes the mover model answers move_req; bench is AXI4-Lite master.
`timescale 1ns/10ps
module dcs_channel_regs_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic trigger, pattern_match, move_req, move_ack, irq, slow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_word;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_resp;
  logic [15:0] src_index, dest_index;
  int failures, comparisons, ack_count;

  dcs_channel_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger(trigger), .pattern_match(pattern_match),
    .move_req(move_req), .move_ack(move_ack),
    .move_src_index(src_index), .move_dest_index(dest_index), .irq(irq)
  );

  dcs_mover_model mover (
    .aclk(aclk), .aresetn(aresetn), .slow(slow),
    .move_req(move_req), .move_ack(move_ack)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = !aclk;
  end

  always @(posedge aclk) begin
    if (move_req && move_ack) ack_count++;
  end

  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    @(posedge aclk);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid && bready && aw_done && w_done) begin
        last_resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd_word = rdata;
        last_resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rd_word);
  endtask

  task automatic fire(input bit pat);
    @(posedge aclk);
    if (pat) pattern_match <= 1'b1;
    else trigger <= 1'b1;
    @(posedge aclk);
    pattern_match <= 1'b0;
    trigger <= 1'b0;
  endtask

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    repeat (2) @(posedge aclk);
    while (move_req !== 1'b0 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (n >= lim) chk("idle wait", 0, 1);
  endtask

  // Sizes, clear all flags, unmask all, then the control word
  task automatic setup(input logic [31:0] s, dl, c, ctl);
    wr(dcs_pkg::OFS_SRC_LENGTH, s);
    wr(dcs_pkg::OFS_DEST_LENGTH, dl);
    wr(dcs_pkg::OFS_BYTES_PER_TRIGGER, c);
    wr(dcs_pkg::OFS_INT_STATUS, 32'h0000_003f);
    wr(dcs_pkg::OFS_INT_MASK, 32'h0000_003f);
    wr(dcs_pkg::OFS_CONTROL, ctl);
    ack_count = 0;
  endtask

  initial begin
    repeat (90000) @(posedge aclk);
    failures++;
    report_and_stop();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {trigger, pattern_match, slow} = 3'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    failures = 0;
    comparisons = 0;
    ack_count = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk(8'(4 * i), 32'h0);
    wr(dcs_pkg::OFS_DEST_LENGTH, 32'hffff_0005);
    chk("bresp", 32'(dcs_pkg::RESP_OKAY), 32'(last_resp));
    rdchk(dcs_pkg::OFS_DEST_LENGTH, 32'h0000_0005);
    wr(dcs_pkg::OFS_BYTES_PER_TRIGGER, 32'h5a5a_0003);
    rdchk(dcs_pkg::OFS_BYTES_PER_TRIGGER, 32'h0000_0003);
    wr(dcs_pkg::OFS_SRC_PROGRESS, 32'hffff_1234);
    rdchk(dcs_pkg::OFS_SRC_PROGRESS, 32'h0);
    wr(dcs_pkg::OFS_DEST_PROGRESS, 32'hffff_4321);
    rdchk(dcs_pkg::OFS_DEST_PROGRESS, 32'h0);
    wr(8'h20, 32'h0000_0001);
    chk("bresp", 32'(dcs_pkg::RESP_SLVERR), 32'(last_resp));
    rdchk(8'h20, 32'h0);
    chk("rresp", 32'(dcs_pkg::RESP_SLVERR), 32'(last_resp));
    // Disabled channel ignores a trigger
    fire(0);
    repeat (2) @(posedge aclk);
    chk("move_req", 0, 32'(move_req));
    // Two cells of two bytes fill a four-byte region
    setup(32'h4, 32'h4, 32'h2, 32'h1);
    fire(0);
    wait_idle(100);
    chk("acks", 2, ack_count);
    rdchk(dcs_pkg::OFS_SRC_PROGRESS, 32'h2);
    rdchk(dcs_pkg::OFS_DEST_PROGRESS, 32'h2);
    chk("src_index", 2, 32'(src_index));
    chk("dest_index", 2, 32'(dest_index));
    rdchk(dcs_pkg::OFS_INT_STATUS, 32'h0000_0015);
    chk("irq", 1, 32'(irq));
    wr(dcs_pkg::OFS_INT_STATUS, 32'h0000_003f);
    rdchk(dcs_pkg::OFS_INT_STATUS, 32'h0);
    chk("irq", 0, 32'(irq));
    fire(0);
    wait_idle(100);
    rdchk(dcs_pkg::OFS_SRC_PROGRESS, 32'h0);
    rdchk(dcs_pkg::OFS_DEST_PROGRESS, 32'h0);
    rdchk(dcs_pkg::OFS_INT_STATUS, 32'h0000_002b);
    chk("irq", 1, 32'(irq));
    wr(dcs_pkg::OFS_INT_MASK, 32'h0);
    chk("irq", 0, 32'(irq));
    // Zero lengths mean a 65,536-byte cell and region
    setup(32'h0, 32'h0, 32'h0, 32'h1);
    fire(0);
    wait_idle(70000);
    chk("acks", 65536, ack_count);
    rdchk(dcs_pkg::OFS_INT_STATUS, 32'h0000_003f);
    rdchk(dcs_pkg::OFS_DEST_PROGRESS, 32'h0);
    // Pattern hit in mid-cell with a slow mover
    slow <= 1'b1;
    setup(32'h8, 32'h8, 32'h8, 32'h3);
    fire(0);
    repeat (6) @(posedge aclk);
    fire(1);
    repeat (2) @(posedge aclk);
    chk("move_req", 0, 32'(move_req));
    rdchk(dcs_pkg::OFS_SRC_PROGRESS, 32'h0);
    chk("src_index", 0, 32'(src_index));
    rdchk(dcs_pkg::OFS_DEST_PROGRESS, 32'(ack_count));
    rd(dcs_pkg::OFS_INT_STATUS);
    chk("block flag", 1, 32'(rd_word[1]));
    report_and_stop();
  end
endmodule
